// [verilog/cpd_defs.vh]
`ifndef CPD_DEFS_VH
`define CPD_DEFS_VH
// MMIO offsets
`define CPD_ADDR_W 22
`define CPD_OFS_TRIGGER 22'h10_0108
`define CPD_OFS_SHUTOFF 22'h10_3428
// Bit positions in the shutoff mask (adjustable layout)
`define CPD_BIT_VIDIN 0
`define CPD_BIT_VIDOUT 1
`define CPD_BIT_AUDIN 2
`define CPD_BIT_AUDOUT 3
`define CPD_BIT_DIGAUD 4
`define CPD_BIT_SSU 5
`define CPD_BIT_JTAG 6
`define CPD_BIT_VLDEC 7
`define CPD_BIT_BOOTI2C 8
`define CPD_BIT_IMGCP 9
`define CPD_SHUTOFF_RST 32'h0000_0000
`define CPD_RDATA_RST 32'h0000_0000
// Wake-up time in SDRAM clock cycles
`define CPD_WAKE_CYCLES 20
`define CPD_CNT_W 8
// Spare drain cycle covering the busy synchroniser delay
`define CPD_DRAIN_CNT 8'h01
// Stay-awake vector width
`define CPD_NAWAKE 7
// Sequencer states
`define CPD_ST_RUN 3'h0
`define CPD_ST_DRAIN 3'h1
`define CPD_ST_ENTER 3'h2
`define CPD_ST_SLEEP 3'h3
`define CPD_ST_EXIT 3'h4
`define CPD_ST_DONE 3'h5
`endif

// [verilog/cpd_sync2.v]
`timescale 1ns/1ps
module cpd_sync2 #(
	parameter W = 1
) (
	// Clock and reset
	input wire clock,
	input wire rst_b,
	// Data
	input wire [W-1:0] asyncIn,
	output reg [W-1:0] syncOut
);
	reg [W-1:0] stage1_q;

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			stage1_q <= {W{1'b0}};
			syncOut <= {W{1'b0}};
		end else begin
			stage1_q <= asyncIn;
			syncOut <= stage1_q;
		end
	end
endmodule

// [verilog/cpd_power_ctrl.v]
// What this block does
// RULE1 - Trigger write starts sleep, write held pending
// RULE2 - Trigger write completes only after wake-up
// RULE3 - Accepted interrupt wakes the chip
// RULE4 - Awake unit highway request wakes the chip
// RULE5 - Let running SDRAM transfer finish first
// RULE6 - Self refresh, wait, assert chip sleep
// RULE7 - Participating units gate clocks during sleep
// RULE8 - Always-on logic and stay-awake units keep clocks
// RULE9 - Wake: drop sleep, exit refresh, complete write
// RULE10 - Wake-up takes about twenty SDRAM cycles
// RULE11 - Seven units have stay-awake bits, default clear
// RULE12 - Decoder, boot/I2C, coprocessor always sleep
// RULE13 - Interrupt controller and PCI never sleep
// RULE14 - Software rewrites trigger after each wake
// RULE15 - Trigger holds nothing; read undefined, harmless
// RULE16 - Shutoff bit one powers unit off
// RULE17 - Shutoff bit for each sleep-capable unit
// RULE18 - Unassigned shutoff bits read as zero
// RULE19 - Trigger and shutoff writes are independent
// RULE20 - Software disables unit before shutting off
// RULE21 - Shutoff bit positions are parameters
`timescale 1ns/1ps
`include "cpd_defs.vh"
module cpd_power_ctrl #(
	parameter BIT_VIDIN = `CPD_BIT_VIDIN, //RULE21
	parameter BIT_VIDOUT = `CPD_BIT_VIDOUT,
	parameter BIT_AUDIN = `CPD_BIT_AUDIN,
	parameter BIT_AUDOUT = `CPD_BIT_AUDOUT,
	parameter BIT_DIGAUD = `CPD_BIT_DIGAUD,
	parameter BIT_SSU = `CPD_BIT_SSU,
	parameter BIT_JTAG = `CPD_BIT_JTAG,
	parameter BIT_VLDEC = `CPD_BIT_VLDEC,
	parameter BIT_BOOTI2C = `CPD_BIT_BOOTI2C,
	parameter BIT_IMGCP = `CPD_BIT_IMGCP,
	parameter WAKE_CYCLES = `CPD_WAKE_CYCLES
) (
	// Clock and reset
	input wire clock,
	input wire rst_b,
	// MMIO access, one-cycle request, held until done
	input wire mmioReq,
	input wire mmioWrite,
	input wire [`CPD_ADDR_W-1:0] mmioAddr,
	input wire [31:0] mmioWdata,
	output reg mmioDone,
	output reg [31:0] mmioRdata,
	// Wake sources (from other logic, asynchronous)
	input wire irqAccepted,
	input wire [`CPD_NAWAKE-1:0] highwayReq,
	// Stay-awake bits from the seven units
	input wire [`CPD_NAWAKE-1:0] stayAwake,
	// SDRAM controller handshake
	input wire sdramBusy,
	output reg selfRefreshReq,
	input wire selfRefreshAck,
	// Chip sleep and clock gating
	output reg globalSleep,
	output reg [`CPD_NAWAKE-1:0] awakeClkOff,
	output reg vldClkOff,
	output reg bootClkOff,
	output reg icpClkOff,
	output reg vicClkOff,
	output reg pciClkOff,
	input wire vicIdle,
	input wire pciIdle,
	// Per-unit power off
	output reg [31:0] unitShutoff
);
	localparam ST_RUN = `CPD_ST_RUN;
	localparam ST_DRAIN = `CPD_ST_DRAIN;
	localparam ST_ENTER = `CPD_ST_ENTER;
	localparam ST_SLEEP = `CPD_ST_SLEEP;
	localparam ST_EXIT = `CPD_ST_EXIT;
	localparam ST_DONE = `CPD_ST_DONE;
	localparam [31:0] WAKE_LAST = WAKE_CYCLES - 1;
	localparam [`CPD_CNT_W-1:0] WAKE_CNT = WAKE_LAST[`CPD_CNT_W-1:0];

	// Mask of bits that belong to a unit
	localparam [31:0] ASSIGNED = (32'h0000_0001 << BIT_VIDIN) |
		(32'h0000_0001 << BIT_VIDOUT) | (32'h0000_0001 << BIT_AUDIN) |
		(32'h0000_0001 << BIT_AUDOUT) | (32'h0000_0001 << BIT_DIGAUD) |
		(32'h0000_0001 << BIT_SSU) | (32'h0000_0001 << BIT_JTAG) |
		(32'h0000_0001 << BIT_VLDEC) | (32'h0000_0001 << BIT_BOOTI2C) |
		(32'h0000_0001 << BIT_IMGCP);

	function addrHit;
		input [`CPD_ADDR_W-1:0] a;
		input [`CPD_ADDR_W-1:0] ofs;
		begin
			addrHit = (a == ofs);
		end
	endfunction

	wire irqSync;
	wire [`CPD_NAWAKE-1:0] hwSync;
	wire [`CPD_NAWAKE-1:0] awakeSync;
	wire busySync;
	wire srAckSync;
	wire vicIdleSync;
	wire pciIdleSync;

	// One synchroniser per source keeps each crossing easy to audit
	cpd_sync2 #(.W(1)) uSyncIrq (
		.clock(clock),
		.rst_b(rst_b),
		.asyncIn(irqAccepted),
		.syncOut(irqSync)
	);

	cpd_sync2 #(.W(`CPD_NAWAKE)) uSyncHw (
		.clock(clock),
		.rst_b(rst_b),
		.asyncIn(highwayReq),
		.syncOut(hwSync)
	);

	cpd_sync2 #(.W(`CPD_NAWAKE)) uSyncAwake (
		.clock(clock),
		.rst_b(rst_b),
		.asyncIn(stayAwake),
		.syncOut(awakeSync)
	);

	cpd_sync2 #(.W(1)) uSyncBusy (
		.clock(clock),
		.rst_b(rst_b),
		.asyncIn(sdramBusy),
		.syncOut(busySync)
	);

	cpd_sync2 #(.W(1)) uSyncAck (
		.clock(clock),
		.rst_b(rst_b),
		.asyncIn(selfRefreshAck),
		.syncOut(srAckSync)
	);

	cpd_sync2 #(.W(1)) uSyncVic (
		.clock(clock),
		.rst_b(rst_b),
		.asyncIn(vicIdle),
		.syncOut(vicIdleSync)
	);

	cpd_sync2 #(.W(1)) uSyncPci (
		.clock(clock),
		.rst_b(rst_b),
		.asyncIn(pciIdle),
		.syncOut(pciIdleSync)
	);

	reg [2:0] state_q;
	reg [2:0] state_d;
	reg [`CPD_CNT_W-1:0] cnt_q;
	reg [`CPD_CNT_W-1:0] cnt_d;
	reg [31:0] shutoff_q;
	reg [31:0] shutoff_d;
	reg pendWr_q;
	reg pendWr_d;

	wire isTrig = addrHit(mmioAddr, `CPD_OFS_TRIGGER);
	wire isShut = addrHit(mmioAddr, `CPD_OFS_SHUTOFF);
	wire trigWr = mmioReq & mmioWrite & isTrig & (state_q == ST_RUN);
	// Only units left awake can raise highway traffic
	wire [`CPD_NAWAKE-1:0] liveReq = hwSync & awakeSync; //RULE4
	wire wakeEvt = irqSync | (|liveReq); //RULE3 RULE4

	always @* begin
		state_d = state_q;
		cnt_d = cnt_q;
		pendWr_d = pendWr_q;
		case (state_q)
		ST_RUN: begin
			if (trigWr) begin
				pendWr_d = 1'b1; //RULE1
				cnt_d = `CPD_DRAIN_CNT;
				state_d = ST_DRAIN;
			end
		end
		ST_DRAIN: begin
			// Busy shows up two edges late; one spare cycle covers it
			if (cnt_q != {`CPD_CNT_W{1'b0}})
				cnt_d = cnt_q - 1'b1;
			else if (!busySync)
				state_d = ST_ENTER; //RULE5
		end
		ST_ENTER: begin
			if (srAckSync)
				state_d = ST_SLEEP; //RULE6
		end
		ST_SLEEP: begin
			if (wakeEvt) begin
				state_d = ST_EXIT; //RULE9
				cnt_d = WAKE_CNT;
			end
		end
		ST_EXIT: begin
			if (!srAckSync && cnt_q == {`CPD_CNT_W{1'b0}})
				state_d = ST_DONE; //RULE10
			else if (cnt_q != {`CPD_CNT_W{1'b0}})
				cnt_d = cnt_q - 1'b1;
		end
		ST_DONE: begin
			pendWr_d = 1'b0; //RULE2
			state_d = ST_RUN;
		end
		default: begin
			state_d = ST_RUN;
			pendWr_d = 1'b0;
		end
		endcase
	end

	always @* begin
		shutoff_d = shutoff_q;
		// Trigger writes never reach the mask
		if (mmioReq && mmioWrite && isShut && state_q == ST_RUN)
			shutoff_d = mmioWdata & ASSIGNED; //RULE16 RULE17 RULE18 RULE19
	end

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			state_q <= ST_RUN;
		else
			state_q <= state_d;
	end

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			cnt_q <= {`CPD_CNT_W{1'b0}};
		else
			cnt_q <= cnt_d;
	end

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			shutoff_q <= `CPD_SHUTOFF_RST;
		else
			shutoff_q <= shutoff_d;
	end

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			pendWr_q <= 1'b0;
		else
			pendWr_q <= pendWr_d;
	end

	// State decodes shared by the registered outputs
	function isState;
		input [2:0] s;
		input [2:0] st;
		begin
			isState = (s == st);
		end
	endfunction

	wire sleepNext = isState(state_d, ST_SLEEP);
	wire enterNext = isState(state_d, ST_ENTER);
	wire idleNow = isState(state_q, ST_RUN);
	wire doneNow = isState(state_q, ST_DONE);
	wire rdReq = mmioReq & ~mmioWrite & idleNow;

	// Trigger write answers only on wake; others next cycle
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			mmioDone <= 1'b0;
		else
			mmioDone <= (mmioReq & ~(mmioWrite & isTrig) &
				idleNow) | doneNow; //RULE1 RULE2
	end

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			mmioRdata <= `CPD_RDATA_RST;
		else if (rdReq)
			mmioRdata <= isShut ? (shutoff_q & ASSIGNED) :
				`CPD_RDATA_RST; //RULE15 RULE18
	end

	// Refresh request drops as soon as sleep ends
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			selfRefreshReq <= 1'b0;
		else
			selfRefreshReq <= enterNext | sleepNext; //RULE6 RULE9
	end

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			globalSleep <= 1'b0;
		else
			globalSleep <= sleepNext; //RULE6 RULE9
	end

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			awakeClkOff <= {`CPD_NAWAKE{1'b0}};
		else
			awakeClkOff <= {`CPD_NAWAKE{sleepNext}} &
				~awakeSync; //RULE7 RULE8 RULE11
	end

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			vldClkOff <= 1'b0;
		else
			vldClkOff <= sleepNext; //RULE12
	end

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			bootClkOff <= 1'b0;
		else
			bootClkOff <= sleepNext; //RULE12
	end

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			icpClkOff <= 1'b0;
		else
			icpClkOff <= sleepNext; //RULE12
	end

	// Self power-down on idle, independent of sleep
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			vicClkOff <= 1'b0;
		else
			vicClkOff <= vicIdleSync & ~irqSync; //RULE13
	end

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			pciClkOff <= 1'b0;
		else
			pciClkOff <= pciIdleSync; //RULE13
	end

	// Mirrors the mask register, updated on the same edge
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			unitShutoff <= `CPD_SHUTOFF_RST;
		else
			unitShutoff <= shutoff_d; //RULE16
	end
endmodule

// [bench/cpd_power_ctrl_assertions.sv]
`timescale 1ns/1ps
`include "cpd_defs.vh"
module cpd_power_ctrl_assertions (
	// Clock and reset
	input wire clock,
	input wire rst_b,
	// Watched ports
	input wire mmioReq,
	input wire mmioWrite,
	input wire [`CPD_ADDR_W-1:0] mmioAddr,
	input wire mmioDone,
	input wire sdramBusy,
	input wire selfRefreshReq,
	input wire selfRefreshAck,
	input wire globalSleep,
	input wire vldClkOff,
	input wire bootClkOff,
	input wire icpClkOff,
	input wire [31:0] unitShutoff
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	wire shutWr = mmioReq && mmioWrite && mmioAddr == `CPD_OFS_SHUTOFF;
	sequence quiet8;
		!mmioDone [*8];
	endsequence
	a_sleep_has_refresh: assert property (globalSleep |-> selfRefreshReq)
		else $error("sleep without refresh");
	a_sleep_after_ack: assert property ($rose(globalSleep) |-> selfRefreshAck)
		else $error("sleep before refresh ack");
	a_refresh_when_idle: assert property ($rose(selfRefreshReq) |-> !$past(sdramBusy))
		else $error("refresh while busy");
	a_fixed_units_gate: assert property (vldClkOff == globalSleep && bootClkOff == globalSleep && icpClkOff == globalSleep)
		else $error("fixed unit gate");
	a_held_in_sleep: assert property (globalSleep |-> !mmioDone)
		else $error("done during sleep");
	a_wake_time: assert property ($fell(globalSleep) |=> quiet8 ##1 quiet8 ##[1:24] mmioDone)
		else $error("wake time wrong");
	a_spare_bits_zero: assert property (unitShutoff[31:10] == 22'h00_0000)
		else $error("spare mask bits set");
	a_mask_kept: assert property (!$stable(unitShutoff) |-> $past(shutWr))
		else $error("mask changed");
endmodule
bind cpd_power_ctrl cpd_power_ctrl_assertions cpd_power_ctrl_assertions_inst (.*);

// [bench/cpd_sdram_model.sv]
`timescale 1ns/1ps
module cpd_sdram_model (
	// Clock and reset
	input wire clock,
	input wire rst_b,
	// Bench control
	input wire startXfer,
	input wire [3:0] lat,
	// Controller side
	input wire selfRefreshReq,
	output reg sdramBusy,
	output reg selfRefreshAck
);
	reg [3:0] busyCnt_q;
	reg [3:0] ackCnt_q;
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			busyCnt_q <= 4'h0;
			ackCnt_q <= 4'h0;
			sdramBusy <= 1'b0;
			selfRefreshAck <= 1'b0;
		end else begin
			busyCnt_q <= startXfer ? lat : busyCnt_q - {3'h0, busyCnt_q != 4'h0};
			sdramBusy <= startXfer || busyCnt_q > 4'h1;
			// Entry and exit both lag, so slow parts are exercised
			if (selfRefreshReq == selfRefreshAck)
				ackCnt_q <= lat;
			else if (ackCnt_q != 4'h0)
				ackCnt_q <= ackCnt_q - 4'h1;
			else
				selfRefreshAck <= selfRefreshReq;
		end
	end
endmodule

// [bench/tb_top.sv]
`timescale 1ns/1ps
`include "cpd_defs.vh"
module tb_top;
	reg clock = 1'b0;
	reg rst_b = 1'b0;
	reg mmioReq = 1'b0;
	reg mmioWrite = 1'b0;
	reg [`CPD_ADDR_W-1:0] mmioAddr = 22'h00_0000;
	reg [31:0] mmioWdata = 32'h0000_0000;
	reg irqAccepted = 1'b0;
	reg [6:0] highwayReq = 7'h00;
	reg [6:0] stayAwake = 7'h00;
	reg startXfer = 1'b0;
	reg [3:0] lat = 4'h1;
	reg vicIdle = 1'b1;
	reg pciIdle = 1'b1;
	wire mmioDone, sdramBusy, selfRefreshReq, selfRefreshAck, globalSleep;
	wire vldClkOff, bootClkOff, icpClkOff, vicClkOff, pciClkOff;
	wire [6:0] awakeClkOff;
	wire [31:0] mmioRdata, unitShutoff;
	reg [31:0] rd;
	integer failures = 0;
	integer n_tests = 0;
	integer k;
	cpd_power_ctrl cpd_power_ctrl_inst (.*);
	cpd_sdram_model cpd_sdram_model_inst (.*);
	initial begin
		forever #2 clock = ~clock;
	end
	task chk(input [31:0] seen, input [31:0] exp, input [63:0] nm);
		begin
			n_tests = n_tests + 1;
			if (seen !== exp) begin
				failures = failures + 1;
				$display("CHECK FAILED %0s exp %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task end_of_test;
		begin
			if (failures == 0 && n_tests > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	task automatic waitFor(input sel);
		integer i;
		begin
			i = 0;
			while ((sel ? globalSleep : mmioDone) !== 1'b1 && i < 400) begin
				@(posedge clock);
				#1;
				i = i + 1;
			end
			if (i == 400) begin
				failures = failures + 1;
				end_of_test;
			end
		end
	endtask
	task acc(input w, input [21:0] a, input [31:0] d);
		begin
			mmioReq = 1'b1;
			mmioWrite = w;
			mmioAddr = a;
			mmioWdata = d;
			@(posedge clock);
			#1;
			waitFor(1'b0);
			rd = mmioRdata;
			mmioReq = 1'b0;
			@(posedge clock);
			#1;
		end
	endtask
	initial begin
		repeat (20) @(posedge clock);
		#1;
		rst_b = 1'b1;
		repeat (3) @(posedge clock);
		#1;
		chk(unitShutoff, 32'h0000_0000, "mask0");
		chk(pciClkOff, 1'b1, "pcioff");
		chk(vicClkOff, 1'b1, "vicoff");
		vicIdle = 1'b0;
		pciIdle = 1'b0;
		repeat (3) @(posedge clock);
		#1;
		chk(pciClkOff, 1'b0, "pcion");
		chk(vicClkOff, 1'b0, "vicon");
		vicIdle = 1'b1;
		pciIdle = 1'b1;
		acc(1'b1, `CPD_OFS_SHUTOFF, 32'hFFFF_FFFF);
		chk(unitShutoff, 32'h0000_03FF, "mask");
		acc(1'b0, `CPD_OFS_SHUTOFF, 32'h0000_0000);
		chk(rd, 32'h0000_03FF, "maskrd");
		acc(1'b1, `CPD_OFS_SHUTOFF, 32'h0000_0205);
		acc(1'b0, `CPD_OFS_TRIGGER, 32'h0000_0000);
		chk(rd, 32'h0000_0000, "trigrd");
		chk(selfRefreshReq, 1'b0, "srreq");
		acc(1'b0, 22'h00_0004, 32'h0000_0000);
		chk(rd, 32'h0000_0000, "unmap");
		stayAwake = 7'h05;
		for (k = 0; k < 2; k = k + 1) begin
			lat = k ? 4'h9 : 4'h1;
			startXfer = 1'b1;
			@(posedge clock);
			#1;
			startXfer = 1'b0;
			fork
				acc(1'b1, `CPD_OFS_TRIGGER, 32'h0000_0000);
				begin
					waitFor(1'b1);
					chk(awakeClkOff, 7'h7A, "awkoff");
					chk(unitShutoff, 32'h0000_0205, "masks");
					repeat (12) @(posedge clock);
					#1;
					chk(globalSleep, 1'b1, "held");
					irqAccepted = !k;
					highwayReq = {6'h00, k[0]};
					repeat (4) @(posedge clock);
					#1;
					chk(vicClkOff, k, "vicirq");
					irqAccepted = 1'b0;
					highwayReq = 7'h00;
				end
			join
			chk(globalSleep, 1'b0, "woke");
			chk(selfRefreshAck, 1'b0, "srexit");
		end
		repeat (30) @(posedge clock);
		#1;
		chk(globalSleep, 1'b0, "stay");
		end_of_test;
	end
endmodule
